// [flash_seq_regs.svh]
// register offsets, flag positions, command codes and timing counts of the
// flash command sequencer; definitions only, included by the sequencer, the checker and the bench
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------
`define OFS_TIMEBASE_DIV 8'h00
`define OFS_STATUS_FLAGS 8'h04
`define OFS_CMD_CODE 8'h08
`define OFS_CMD_ADDR 8'h0C
`define OFS_CMD_DATA 8'h10
`define OFS_PROT_LOW 8'h14
`define OFS_PROT_HIGH 8'h18
`define OFS_PROT_CTRL 8'h1C
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_CLEAR 8'h24
`define OFS_IRQ_ENABLE 8'h28

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define BIT_BUF_EMPTY 7
`define BIT_CMD_DONE 6
`define BIT_PROTECTION_VIOLATION_FLAG 5
`define BIT_ACCESS_ERROR_FLAG 4
`define BIT_BLANK 2
`define BIT_DIV_LOADED 7
`define BIT_PROT_EN 0
`define IRQ_BUF_EMPTY 0
`define IRQ_CMD_DONE 1
`define DIV_RESET 7'h00
`define ROW_MSB 15
`define ROW_LSB 6

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_ERASE_VERIFY 8'h05
`define CMD_WORD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// ----------------------------------------------------------------------
// timing counts in timebase ticks
// ----------------------------------------------------------------------
`define HV_RAMP_TICKS 16'h0002
`define VERIFY_TICKS 16'h0010
`define PROGRAM_TICKS 16'h0006
`define SECTOR_ERASE_TICKS 16'h0FA0
`define MASS_ERASE_TICKS 16'h4E20

`endif

// [flash_seq_pkg.sv]
// types shared by the flash command sequencer modules
// assumes nothing of its surroundings
package flash_seq_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_EXEC = 2'b10,
    ST_RETIRE = 2'b11
  } seq_state_t;
  // progress of the software write sequence
  typedef enum logic [1:0] {
    WS_EMPTY = 2'b00,
    WS_DATA = 2'b01,
    WS_CMD = 2'b10
  } wseq_t;
endpackage

// [timebase_divider.sv]
// slow timebase for the program and erase sequencer
// assumes pclk is the oscillator clock and div_value is stable while busy
`timescale 1ns/1ps
module timebase_divider (
  input wire logic pclk, // oscillator and bus clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic enable, // divider value has been loaded
  input wire logic [6:0] div_value, // tick every 8 x (div_value + 1) cycles
  output logic tick // one-cycle timebase pulse
);
  logic [6:0] count;
  logic [2:0] prescale;

  // ------------------------------------------------------------------
  // divider: fixed divide by eight, then one tick every div_value + 1
  // prescaled steps; the eight lets a fast clock reach the slow tick range
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 3'h0;
      count <= 7'h00;
      tick <= 1'b0;
    end else if (ce) begin
      prescale <= enable ? prescale + 3'h1 : 3'h0;
      if (!enable || (prescale == 3'h7 && count == div_value)) begin
        count <= 7'h00;
      end else if (prescale == 3'h7) begin
        count <= count + 7'h01;
      end
      tick <= enable && prescale == 3'h7 && count == div_value;
    end
  end
endmodule

// [command_queue.sv]
// two-entry queue of command, address and data: buffer plus executing stage
// assumes the caller never pushes when full nor pops when empty
`timescale 1ns/1ps
module command_queue (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic push, // store a new entry
  input wire logic pop, // retire the head entry
  input wire logic flush, // drop every entry
  input wire logic [39:0] push_entry, // {cmd, addr, data}
  output logic [39:0] head_entry, // executing entry
  output logic [39:0] next_entry, // waiting entry
  output logic [1:0] count // entries held
);
  logic [39:0] slots [0:1];
  logic rd_ptr;
  logic wr_ptr;

  assign head_entry = slots[rd_ptr];
  assign next_entry = slots[~rd_ptr];

  // ------------------------------------------------------------------
  // storage: depth two is what lets one command wait behind another
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slots[0] <= 40'h00_0000_0000;
      slots[1] <= 40'h00_0000_0000;
    end else if (ce && push && !flush) begin
      slots[wr_ptr] <= push_entry;
    end
  end

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else if (ce) begin
      if (flush) begin
        rd_ptr <= 1'b0;
        wr_ptr <= 1'b0;
        count <= 2'h0;
      end else begin
        if (push) begin
          wr_ptr <= ~wr_ptr;
        end
        if (pop) begin
          rd_ptr <= ~rd_ptr;
        end
        count <= count + {1'b0, push} - {1'b0, pop};
      end
    end
  end
endmodule

// [flash_command_sequencer.sv]
// flash command front end: apb registers, two-stage command queue,
// protection and error checks, and the program and erase sequencer
// assumes one clock pclk that is also the oscillator clock; stop_req comes
// from logic on pclk, array_erased_pin from outside and is synchronised
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_command_sequencer import flash_seq_pkg::*; #(
  parameter logic [15:0] PROGRAM_TICKS = `PROGRAM_TICKS,
  parameter logic [15:0] SECTOR_ERASE_TICKS = `SECTOR_ERASE_TICKS,
  parameter logic [15:0] MASS_ERASE_TICKS = `MASS_ERASE_TICKS
) (
  input wire logic pclk, // bus and oscillator clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic stop_req, // cpu stop request
  input wire logic array_erased_pin, // array reports all cells erased
  output logic irq, // level interrupt
  output logic hv_on, // high voltage generator enable
  output logic [7:0] array_op, // command code under execution, 0 when none
  output logic [15:0] array_addr, // array address under execution
  output logic [15:0] array_data // word being programmed
);
  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic setup;
  logic wr_ack;
  logic wr_div, wr_status, wr_cmd, wr_addr, wr_data;
  logic wr_plow, wr_phigh, wr_pctrl, wr_iclr, wr_ien;
  logic [6:0] div_value;
  logic div_loaded;
  logic tick;
  logic protection_violation_flag, access_error_flag, blank;
  logic [7:0] hold_cmd;
  logic [15:0] hold_addr, hold_data;
  wseq_t wseq;
  logic [15:0] prot_low, prot_high;
  logic prot_en;
  logic [1:0] irq_status, irq_enable;
  logic buf_empty, cmd_done, buf_empty_d, cmd_done_d;
  logic erased_meta, erased_sync;
  seq_state_t state;
  logic [15:0] tick_cnt;
  logic [39:0] head_entry, next_entry;
  logic [1:0] q_count;
  logic q_full, busy, pop, flush;
  logic legal_code, in_region, prot_hit;
  logic launch_req, launch_ok, launch_protection_violation_flag;
  logic seq_err, set_access_error_flag, verify_pass;
  logic [7:0] head_cmd, next_cmd;
  logic [15:0] head_addr, next_addr;
  logic keep_hv;
  logic [15:0] op_ticks;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_ack = psel && penable && pready && pwrite;
  assign wr_div = wr_ack && paddr == `OFS_TIMEBASE_DIV;
  assign wr_status = wr_ack && paddr == `OFS_STATUS_FLAGS;
  assign wr_cmd = wr_ack && paddr == `OFS_CMD_CODE;
  assign wr_addr = wr_ack && paddr == `OFS_CMD_ADDR;
  assign wr_data = wr_ack && paddr == `OFS_CMD_DATA;
  assign wr_plow = wr_ack && paddr == `OFS_PROT_LOW;
  assign wr_phigh = wr_ack && paddr == `OFS_PROT_HIGH;
  assign wr_pctrl = wr_ack && paddr == `OFS_PROT_CTRL;
  assign wr_iclr = wr_ack && paddr == `OFS_IRQ_CLEAR;
  assign wr_ien = wr_ack && paddr == `OFS_IRQ_ENABLE;

  // ready follows every setup cycle by one clock: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setup;
    end
  end

  // read data and error are latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `OFS_TIMEBASE_DIV: prdata[7:0] <= {div_loaded, div_value};
        `OFS_STATUS_FLAGS: begin
          prdata[`BIT_BUF_EMPTY] <= buf_empty;
          prdata[`BIT_CMD_DONE] <= cmd_done;
          prdata[`BIT_PROTECTION_VIOLATION_FLAG] <= protection_violation_flag;
          prdata[`BIT_ACCESS_ERROR_FLAG] <= access_error_flag;
          prdata[`BIT_BLANK] <= blank;
        end
        `OFS_CMD_CODE: prdata[7:0] <= hold_cmd;
        `OFS_CMD_ADDR: prdata[15:0] <= hold_addr;
        `OFS_CMD_DATA: prdata[15:0] <= hold_data;
        `OFS_PROT_LOW: prdata[15:0] <= prot_low;
        `OFS_PROT_HIGH: prdata[15:0] <= prot_high;
        `OFS_PROT_CTRL: prdata[`BIT_PROT_EN] <= prot_en;
        `OFS_IRQ_STATUS: prdata[1:0] <= irq_status;
        `OFS_IRQ_CLEAR: prdata[1:0] <= 2'h0; // write-only, reads zero
        `OFS_IRQ_ENABLE: prdata[1:0] <= irq_enable;
        default: pslverr <= 1'b1;
      endcase
    end else if (ce) begin
      pslverr <= 1'b0; // the error answer stands for the access cycle only
    end
  end

  // ------------------------------------------------------------------
  // timebase divider
  // ------------------------------------------------------------------
  // divider value stays writable; a change mid-command lengthens or shortens the step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_value <= `DIV_RESET;
      div_loaded <= 1'b0;
    end else if (ce && wr_div) begin
      div_value <= pwdata[6:0];
      div_loaded <= 1'b1;
    end
  end

  timebase_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .enable(div_loaded),
    .div_value(div_value),
    .tick(tick)
  );

  // ------------------------------------------------------------------
  // protection region and interrupt configuration
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_low <= 16'h0000;
      prot_high <= 16'h0000;
      prot_en <= 1'b0;
      irq_enable <= 2'h0;
    end else if (ce) begin
      if (wr_plow) prot_low <= pwdata[15:0];
      if (wr_phigh) prot_high <= pwdata[15:0];
      if (wr_pctrl) prot_en <= pwdata[`BIT_PROT_EN];
      if (wr_ien) irq_enable <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------------
  // command checks
  // ------------------------------------------------------------------
  assign legal_code = pwdata[7:0] == `CMD_ERASE_VERIFY ||
                      pwdata[7:0] == `CMD_WORD_PROGRAM ||
                      pwdata[7:0] == `CMD_SECTOR_ERASE ||
                      pwdata[7:0] == `CMD_MASS_ERASE;
  assign in_region = hold_addr >= prot_low && hold_addr <= prot_high;
  // mass erase touches every region, so any protection blocks it
  assign prot_hit = prot_en && (hold_cmd == `CMD_MASS_ERASE ||
                    (hold_cmd != `CMD_ERASE_VERIFY && in_region));
  assign q_full = q_count == 2'h2;
  assign busy = state != ST_IDLE;
  assign launch_req = wr_status && pwdata[`BIT_BUF_EMPTY];
  // both error flags block a launch until software clears them
  assign launch_ok = launch_req && wseq == WS_CMD && div_loaded &&
                     !protection_violation_flag && !access_error_flag && !prot_hit;
  assign launch_protection_violation_flag = launch_req && wseq == WS_CMD && div_loaded &&
                        !protection_violation_flag && !access_error_flag && prot_hit;
  // every step out of order is an access error
  assign seq_err = (wr_addr && wseq != WS_EMPTY) ||
                   (wr_data && (wseq != WS_EMPTY || q_full)) ||
                   (wr_cmd && wseq != WS_DATA) ||
                   (launch_req && (wseq != WS_CMD || !div_loaded));
  assign set_access_error_flag = seq_err || (wr_cmd && wseq == WS_DATA && !legal_code) ||
                      (stop_req && busy);

  // ------------------------------------------------------------------
  // write sequence and holding registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wseq <= WS_EMPTY;
      hold_cmd <= 8'h00;
      hold_addr <= 16'h0000;
      hold_data <= 16'h0000;
    end else if (ce) begin
      if (set_access_error_flag || launch_protection_violation_flag || launch_ok) begin
        wseq <= WS_EMPTY; // an error aborts the sequence under way
      end else begin
        unique case (wseq)
          WS_EMPTY: begin
            if (wr_addr) hold_addr <= pwdata[15:0];
            if (wr_data) begin
              hold_data <= pwdata[15:0];
              wseq <= WS_DATA;
            end
          end
          WS_DATA: begin
            if (wr_cmd) begin
              hold_cmd <= pwdata[7:0];
              wseq <= WS_CMD;
            end
          end
          WS_CMD: wseq <= WS_CMD;
          default: wseq <= WS_EMPTY;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // error and result flags: a hardware set wins over a software clear
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_violation_flag <= 1'b0;
      access_error_flag <= 1'b0;
      blank <= 1'b0;
    end else if (ce) begin
      if (launch_protection_violation_flag) begin
        protection_violation_flag <= 1'b1;
      end else if (wr_status && pwdata[`BIT_PROTECTION_VIOLATION_FLAG]) begin
        protection_violation_flag <= 1'b0;
      end
      if (set_access_error_flag) begin
        access_error_flag <= 1'b1;
      end else if (wr_status && pwdata[`BIT_ACCESS_ERROR_FLAG]) begin
        access_error_flag <= 1'b0;
      end
      if (verify_pass) begin
        blank <= 1'b1;
      end else if (launch_ok) begin
        blank <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // command queue
  // ------------------------------------------------------------------
  command_queue u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .push(launch_ok),
    .pop(pop),
    .flush(flush),
    .push_entry({hold_cmd, hold_addr, hold_data}),
    .head_entry(head_entry),
    .next_entry(next_entry),
    .count(q_count)
  );

  assign head_cmd = head_entry[39:32];
  assign head_addr = head_entry[31:16];
  assign next_cmd = next_entry[39:32];
  assign next_addr = next_entry[31:16];
  assign pop = state == ST_RETIRE && !flush;
  assign flush = stop_req && busy; // stop abandons running and waiting work
  assign buf_empty = !q_full;
  assign cmd_done = !busy && q_count == 2'h0;
  assign verify_pass = pop && head_cmd == `CMD_ERASE_VERIFY && erased_sync;
  // same-row program waiting behind a program: no need to drop the pump
  assign keep_hv = q_count == 2'h2 && head_cmd == `CMD_WORD_PROGRAM &&
                   next_cmd == `CMD_WORD_PROGRAM &&
                   head_addr[`ROW_MSB:`ROW_LSB] == next_addr[`ROW_MSB:`ROW_LSB];

  // step length of the command at the head
  always_comb begin
    unique case (head_cmd)
      `CMD_WORD_PROGRAM: op_ticks = PROGRAM_TICKS;
      `CMD_SECTOR_ERASE: op_ticks = SECTOR_ERASE_TICKS;
      `CMD_MASS_ERASE: op_ticks = MASS_ERASE_TICKS;
      default: op_ticks = `VERIFY_TICKS;
    endcase
  end

  // erased indication arrives from the array side, two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased_meta <= 1'b0;
      erased_sync <= 1'b0;
    end else if (ce) begin
      erased_meta <= array_erased_pin;
      erased_sync <= erased_meta;
    end
  end

  // ------------------------------------------------------------------
  // sequencer: ramp and execute counted in timebase ticks, then retire in one clock
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      tick_cnt <= 16'h0000;
      hv_on <= 1'b0;
      array_op <= 8'h00;
      array_addr <= 16'h0000;
      array_data <= 16'h0000;
    end else if (ce) begin
      if (flush) begin
        state <= ST_IDLE;
        hv_on <= 1'b0;
        array_op <= 8'h00;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (q_count != 2'h0) begin
              if (hv_on || head_cmd == `CMD_ERASE_VERIFY) begin
                state <= ST_EXEC; // pump already up or not needed
                tick_cnt <= op_ticks;
              end else begin
                state <= ST_RAMP;
                hv_on <= 1'b1;
                tick_cnt <= `HV_RAMP_TICKS;
              end
            end
          end
          ST_RAMP: begin
            if (tick) begin
              tick_cnt <= tick_cnt - 16'h0001;
              if (tick_cnt == 16'h0001) begin
                state <= ST_EXEC;
                tick_cnt <= op_ticks;
              end
            end
          end
          ST_EXEC: begin
            array_op <= head_entry[39:32];
            array_addr <= head_entry[31:16];
            array_data <= head_entry[15:0];
            if (tick) begin
              tick_cnt <= tick_cnt - 16'h0001;
              if (tick_cnt == 16'h0001) begin
                state <= ST_RETIRE;
              end
            end
          end
          ST_RETIRE: begin
            array_op <= 8'h00;
            hv_on <= keep_hv;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupts: sticky on the rising edge of each flag
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_empty_d <= 1'b1;
      cmd_done_d <= 1'b1;
      irq_status <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      buf_empty_d <= buf_empty;
      cmd_done_d <= cmd_done;
      for (int i = 0; i < 2; i++) begin
        if (wr_iclr && pwdata[i]) irq_status[i] <= 1'b0;
      end
      if (buf_empty && !buf_empty_d) irq_status[`IRQ_BUF_EMPTY] <= 1'b1;
      if (cmd_done && !cmd_done_d) irq_status[`IRQ_CMD_DONE] <= 1'b1;
      irq <= |(irq_status & irq_enable);
    end
  end
endmodule

// [flash_seq_props.sv]
// assertions on the ports of the flash command sequencer
// assumes it is bound to every flash_command_sequencer instance
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_seq_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // bus error
  input wire logic stop_req, // stop request
  input wire logic hv_on, // high voltage
  input wire logic [7:0] array_op // executing code
);
  // ----------------------------------------------------------------
  // one clock domain, so one default clocking and reset
  // ----------------------------------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // status word in its access cycle
  logic st_rd;
  assign st_rd = pready && !pwrite && paddr == `OFS_STATUS_FLAGS;
  ready_timing_a:
    assert property (psel && !penable && ce |=> pready) else $error("no ready after setup");
  ready_pulse_a:
    assert property (pready |-> psel && penable ##1 !pready) else $error("ready misplaced");
  err_zero_a:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  op_legal_a:
    assert property (array_op != 8'h00 |-> array_op inside {`CMD_ERASE_VERIFY,
      `CMD_WORD_PROGRAM, `CMD_SECTOR_ERASE, `CMD_MASS_ERASE}) else $error("illegal op");
  hv_write_a:
    assert property (array_op inside {8'h20, 8'h40, 8'h41} |-> hv_on) else $error("no hv");
  op_hold_a:
    assert property (array_op != 8'h00 |=> array_op == $past(array_op) || array_op == 8'h00)
      else $error("op changed mid run");
  stop_abort_a:
    assert property (stop_req && array_op != 8'h00 |-> ##[1:3] array_op == 8'h00)
      else $error("stop ignored");
  done_empty_a:
    assert property (st_rd && prdata[6] |-> prdata[7]) else $error("done while full");
  status_res_a:
    assert property (st_rd |-> prdata[31:8] == 24'h0 && prdata[3] == 1'b0 && prdata[1:0] == 2'h0)
      else $error("reserved status bits set");
endmodule
bind flash_command_sequencer flash_seq_props flash_seq_props_inst (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .stop_req, .hv_on, .array_op);

// [flash_command_sequencer_bench.sv]
// self-checking bench for the flash command sequencer over apb
// assumes the design files and the checker are compiled before it
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_command_sequencer_bench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic stop_req = 0, erased = 0, hv_prev = 0, pready, pslverr, irq, hv_on;
  logic [7:0] paddr = 8'h00;
  logic [7:0] array_op;
  logic [15:0] array_addr, array_data;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [64:0] n;
  logic [64:0] notes[$]; // {error, mask, value}
  logic [39:0] ex;
  logic [39:0] ops[$]; // expected executions {op, addr, data}
  logic [7:0] op_prev = 8'h00;
  int failures = 0, checks_done = 0, cycles = 0, hv_falls = 0;
  int seed = 32'hc1ce915a;
  // short counts keep erase runs brief
  flash_command_sequencer #(.PROGRAM_TICKS(16'h0003), .SECTOR_ERASE_TICKS(16'h0005),
    .MASS_ERASE_TICKS(16'h0007)) flash_command_sequencer_inst (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_req,
    .array_erased_pin(erased), .irq, .hv_on, .array_op, .array_addr, .array_data);
  initial forever #5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; the note is judged by the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m = 0, input logic [31:0] v = 0, input logic e = 0);
    notes.push_back({e, m, v});
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic st(input logic [7:0] v);
    apb(0, `OFS_STATUS_FLAGS, 0, 32'hFF, {24'h0, v});
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] c, input logic go = 0);
    logic [15:0] d;
    d = 16'($random(seed));
    if (go) ops.push_back({c, a, d});
    apb(1, `OFS_CMD_ADDR, {16'h0, a});
    apb(1, `OFS_CMD_DATA, {16'h0, d});
    apb(1, `OFS_CMD_CODE, {24'h0, c});
    apb(1, `OFS_STATUS_FLAGS, 32'h80);
  endtask
  task automatic wait_done;
    rd = 0;
    for (int i = 0; i < 4000 && rd[6] !== 1'b1; i++) apb(0, `OFS_STATUS_FLAGS, 0);
    check("done wait", 32'h1, {31'h0, rd[6]});
  endtask
  // monitor: judges each answer, counts hv drops, cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (hv_prev === 1'b1 && hv_on === 1'b0) hv_falls++;
    hv_prev = hv_on;
    if (psel && penable && pready === 1'b1) begin
      n = notes.pop_front();
      check("pslverr", {31'h0, n[64]}, {31'h0, pslverr});
      check("prdata", n[31:0], prdata & n[63:32]);
    end
    // each start of execution takes the oldest expected entry
    if (array_op !== 8'h00 && op_prev === 8'h00) begin
      ex = ops.size() > 0 ? ops.pop_front() : 40'hFF_FFFF_FFFF;
      check("array op", {24'h0, ex[39:32]}, {24'h0, array_op});
      check("array addr", {16'h0, ex[31:16]}, {16'h0, array_addr});
      check("array data", {16'h0, ex[15:0]}, {16'h0, array_data});
    end
    op_prev = array_op;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    st(8'hC0);
    apb(0, 8'h2C, 0, 32'hFFFFFFFF, 0, 1);
    cmd(16'h0040, `CMD_WORD_PROGRAM);
    st(8'hD0);
    apb(1, `OFS_STATUS_FLAGS, 32'h0);
    st(8'hD0);
    apb(1, `OFS_STATUS_FLAGS, 32'h10);
    apb(1, `OFS_TIMEBASE_DIV, 32'h3F);
    apb(0, `OFS_TIMEBASE_DIV, 0, 32'hFF, 32'hBF);
    cmd(16'h0040, 8'h33);
    st(8'hD0);
    apb(1, `OFS_STATUS_FLAGS, 32'h10);
    apb(1, `OFS_PROT_LOW, 32'h0100);
    apb(1, `OFS_PROT_HIGH, 32'h01FF);
    apb(1, `OFS_PROT_CTRL, 32'h1);
    cmd(16'h01FF, `CMD_WORD_PROGRAM);
    st(8'hE0);
    apb(1, `OFS_STATUS_FLAGS, 32'h0);
    cmd(16'h0300, `CMD_WORD_PROGRAM, 1);
    st(8'hE0);
    apb(1, `OFS_STATUS_FLAGS, 32'h20);
    st(8'hC0);
    apb(1, `OFS_STATUS_FLAGS, 32'h80);
    wait_done();
    apb(1, `OFS_IRQ_CLEAR, 32'h3);
    apb(1, `OFS_IRQ_ENABLE, 32'h3);
    hv_falls = 0;
    cmd(16'h0200, `CMD_WORD_PROGRAM, 1);
    cmd(16'h0210, `CMD_WORD_PROGRAM, 1);
    st(8'h00);
    wait_done();
    check("hv drops", 1, hv_falls);
    apb(0, `OFS_IRQ_STATUS, 0, 32'h3, 32'h3);
    check("irq", 1, {31'h0, irq});
    apb(1, `OFS_IRQ_CLEAR, 32'h3);
    apb(1, `OFS_IRQ_ENABLE, 32'h0);
    hv_falls = 0;
    cmd(16'h0200, `CMD_WORD_PROGRAM, 1);
    cmd(16'h0400, `CMD_WORD_PROGRAM, 1);
    wait_done();
    check("hv drops", 2, hv_falls);
    apb(1, `OFS_IRQ_CLEAR, 32'h3);
    erased <= 1;
    cmd(16'h0000, `CMD_ERASE_VERIFY, 1);
    wait_done();
    st(8'hC4);
    apb(0, `OFS_IRQ_STATUS, 0, 32'h3, 32'h2);
    check("irq masked", 0, {31'h0, irq});
    cmd(16'h0800, `CMD_SECTOR_ERASE, 1);
    repeat (1200) @(posedge pclk);
    stop_req <= 1;
    @(posedge pclk);
    stop_req <= 0;
    st(8'hD0);
    apb(1, `OFS_STATUS_FLAGS, 32'h10);
    cmd(16'h0000, `CMD_MASS_ERASE);
    st(8'hE0);
    check("ops left", 0, ops.size());
    end_sim();
  end
endmodule
